// file: design/alu_pkg.sv
// shared types and constants of the integer execution datapath
package alu_pkg;

    // ------------------------------------------------------------
    // operand widths and masks
    // ------------------------------------------------------------
    localparam int unsigned byte_msb    = 7;              // top bit of a byte operand
    localparam int unsigned word_msb    = 15;             // top bit of a word operand
    localparam int unsigned double_msb  = 31;             // top bit of a register pair
    localparam logic [31:0] byte_mask   = 32'h000000ff;   // byte lanes kept
    localparam logic [31:0] word_mask   = 32'h0000ffff;   // word lanes kept
    localparam logic [31:0] double_mask = 32'hffffffff;   // whole pair kept
    localparam logic [31:0] bool_true   = 32'h00000001;   // boolean one
    localparam logic [31:0] bool_false  = 32'h00000000;   // boolean zero

    // ------------------------------------------------------------
    // operations issued by the decoder
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        move_sized          = 5'h00,
        move_byte_sign_ext  = 5'h01,
        move_byte_zero_ext  = 5'h02,
        move_word_sign_ext  = 5'h03,
        move_word_zero_ext  = 5'h04,
        move_double         = 5'h05,
        add_sized           = 5'h06,
        add_carry_sized     = 5'h07,
        add_double          = 5'h08,
        mac_fractional      = 5'h09,
        mac_signed          = 5'h0a,
        mac_unsigned        = 5'h0b,
        mult_sized          = 5'h0c,
        mult_signed_byte    = 5'h0d,
        mult_signed_word    = 5'h0e,
        mult_unsigned_word  = 5'h0f,
        sub_sized           = 5'h10,
        sub_double          = 5'h11,
        sub_borrow_sized    = 5'h12,
        compare_sized       = 5'h13,
        compare_double      = 5'h14,
        branch_if_zero      = 5'h15,
        branch_if_nonzero   = 5'h16,
        and_sized           = 5'h17,
        and_double          = 5'h18,
        or_sized            = 5'h19,
        or_double           = 5'h1a,
        xor_sized           = 5'h1b,
        xor_double          = 5'h1c,
        save_condition      = 5'h1d
    } alu_op_t;

    // operand size for the sized forms
    typedef enum logic [1:0] {
        size_byte   = 2'h0,
        size_word   = 2'h1,
        size_double = 2'h2
    } op_size_t;

    // condition selector
    typedef enum logic [3:0] {
        cond_eq = 4'h0, cond_ne = 4'h1, cond_cs = 4'h2, cond_cc = 4'h3,
        cond_hi = 4'h4, cond_ls = 4'h5, cond_gt = 4'h6, cond_le = 4'h7,
        cond_fs = 4'h8, cond_fc = 4'h9, cond_lo = 4'ha, cond_hs = 4'hb,
        cond_lt = 4'hc, cond_ge = 4'hd
    } cond_t;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        alu_op_t     op;        // operation
        op_size_t    size;      // byte or word for sized forms
        cond_t       cond;      // condition for save_condition
        logic        use_imm;   // second operand is the immediate
        logic [31:0] dest;      // {higher reg, lower reg} of destination
        logic [31:0] src;       // {higher reg, lower reg} of source
        logic [15:0] src2;      // second source of the accumulates
        logic [31:0] imm;       // immediate constant
    } request_t;

    typedef struct packed {
        logic carry;            // carry out or borrow
        logic zero;             // result or difference is zero
        logic neg;              // signed less-than from compare
        logic low;              // unsigned less-than from compare
        logic ovf;              // signed overflow
    } flags_t;

    typedef struct packed {
        logic        valid;         // answer present
        logic [31:0] result;        // {high word, low word}
        logic        wr_lo;         // write lower register
        logic        wr_hi;         // write higher register
        logic        branch_taken;  // compare-with-zero decision
    } answer_t;

    localparam flags_t  flags_reset  = '0;   // flags after reset
    localparam answer_t answer_reset = '0;   // idle answer

endpackage

// file: design/risc_integer_alu_datapath.sv
// integer execution datapath: moves, add, subtract, compare, multiply, logic, conditions
//
// Overview of operation
// RL1: sized operations come in byte and word forms
// RL2: condition selector picks tested condition from set
// RL3: sign-extend byte to word, word to pair
// RL4: zero-extend byte to word, word to pair
// RL5: load pair from immediate or another pair
// RL6: 32-bit add of pair with pair/immediate
// RL7: signed mac into pair, fractional Q15 variant
// RL8: unsigned mac adds product into pair
// RL9: sized multiply keeps 8 or 16 bits
// RL10: signed byte multiply gives full 16 bits
// RL11: word multiplies write full product to pair
// RL12: sized subtract writes destination minus source
// RL13: carry forms include previous carry or borrow
// RL14: 32-bit subtract of pair minus pair/immediate
// RL15: compares set flags, write no register
// RL16: branch when source equals or differs from zero
// RL17: sized AND into destination
// RL18: sized OR into destination
// RL19: sized XOR into destination
// RL20: 32-bit AND, OR, XOR on pairs
// RL21: save condition as one or zero
// RL22: pair low bits in lower register
// RL23: add, subtract, compare update status flags
`timescale 1ns/1ns
module risc_integer_alu_datapath (
    input  wire logic              sys_clk,     // core clock, 250 MHz
    input  wire logic              reset,       // synchronous, active high
    input  wire logic              req_valid,   // one-cycle issue strobe
    input  wire alu_pkg::request_t req,         // operation and operands
    input  wire logic              flags_load,  // status written by the core
    input  wire alu_pkg::flags_t   flags_in,    // value for flags_load
    output alu_pkg::answer_t       ans,         // registered answer
    output alu_pkg::flags_t        flags        // registered status flags
);

    // ------------------------------------------------------------
    // operand selection
    // ------------------------------------------------------------
    logic [31:0] opnd_a;          // destination value
    logic [31:0] opnd_b;          // source or immediate
    logic [31:0] mask;            // lanes of the chosen width
    logic [31:0] am;              // masked destination
    logic [31:0] bm;              // masked source
    int unsigned msb;             // top bit index of the width
    logic [32:0] sum;             // add with carry space
    logic [32:0] diff;            // subtract with borrow space
    logic        cin;             // carry/borrow fed in
    logic [15:0] mul_x;           // multiplier operand x
    logic [15:0] mul_y;           // multiplier operand y
    logic [31:0] prod_s;          // signed 16x16 product
    logic [31:0] prod_u;          // unsigned 16x16 product
    logic [15:0] prod_sb;         // signed 8x8 product
    logic        cond_true;       // selected condition holds
    logic        src_is_zero;     // compare-with-zero test
    alu_pkg::answer_t next_ans;   // answer for next edge
    alu_pkg::flags_t  next_flags; // flags for next edge

    // width follows the size field for sized forms, pair for double forms
    always_comb begin
        opnd_a = req.dest;                                         // RL22
        opnd_b = req.use_imm ? req.imm : req.src;                  // RL22
        case (req.op)
            alu_pkg::move_double, alu_pkg::add_double, alu_pkg::sub_double,
            alu_pkg::compare_double, alu_pkg::and_double, alu_pkg::or_double,
            alu_pkg::xor_double: begin
                mask = alu_pkg::double_mask;
                msb  = alu_pkg::double_msb;
            end
            default: begin
                if (req.size == alu_pkg::size_byte) begin            // RL1
                    mask = alu_pkg::byte_mask;
                    msb  = alu_pkg::byte_msb;
                end else begin                                       // RL1
                    mask = alu_pkg::word_mask;
                    msb  = alu_pkg::word_msb;
                end
            end
        endcase
        am = opnd_a & mask;
        bm = opnd_b & mask;
    end

    // ------------------------------------------------------------
    // adder, subtractor and multipliers
    // ------------------------------------------------------------
    // carry forms take the previous carry; borrow shares the carry flag
    always_comb begin
        cin  = ((req.op == alu_pkg::add_carry_sized) || (req.op == alu_pkg::sub_borrow_sized))
               ? flags.carry : 1'b0;                                // RL13
        sum  = {1'b0, am} + {1'b0, bm} + {32'h00000000, cin};       // RL6 RL13
        diff = {1'b0, am} - {1'b0, bm} - {32'h00000000, cin};       // RL12 RL14 RL13
        // accumulates use the two sources, word multiplies use the low dest word
        if ((req.op == alu_pkg::mac_fractional) || (req.op == alu_pkg::mac_signed) ||
            (req.op == alu_pkg::mac_unsigned)) begin
            mul_x = req.src[15:0];
            mul_y = req.src2;
        end else begin
            mul_x = opnd_a[15:0];                                    // RL11
            mul_y = opnd_b[15:0];
        end
        prod_s  = 32'($signed(mul_x) * $signed(mul_y));
        prod_u  = 32'(mul_x * mul_y);
        prod_sb = 16'($signed(opnd_a[7:0]) * $signed(opnd_b[7:0]));  // RL10
    end

    // ------------------------------------------------------------
    // condition evaluation
    // ------------------------------------------------------------
    // conditions read the flags left by the previous operation
    always_comb begin
        case (req.cond)                                              // RL2
            alu_pkg::cond_eq: cond_true = flags.zero;
            alu_pkg::cond_ne: cond_true = !flags.zero;
            alu_pkg::cond_cs: cond_true = flags.carry;
            alu_pkg::cond_cc: cond_true = !flags.carry;
            alu_pkg::cond_hi: cond_true = !flags.low && !flags.zero;
            alu_pkg::cond_ls: cond_true = flags.low || flags.zero;
            alu_pkg::cond_gt: cond_true = !flags.neg && !flags.zero;
            alu_pkg::cond_le: cond_true = flags.neg || flags.zero;
            alu_pkg::cond_fs: cond_true = flags.ovf;
            alu_pkg::cond_fc: cond_true = !flags.ovf;
            alu_pkg::cond_lo: cond_true = flags.low;
            alu_pkg::cond_hs: cond_true = !flags.low;
            alu_pkg::cond_lt: cond_true = flags.neg;
            alu_pkg::cond_ge: cond_true = !flags.neg;
            default:          cond_true = 1'b0;   // undefined codes never hold
        endcase
        src_is_zero = ((req.src & mask) == alu_pkg::bool_false);     // RL16
    end

    // ------------------------------------------------------------
    // result and flag selection
    // ------------------------------------------------------------
    // sized results merge into dest so the untouched upper bits survive
    always_comb begin
        next_ans   = alu_pkg::answer_reset;
        next_flags = flags_load ? flags_in : flags;
        if (req_valid) begin
            next_ans.valid = 1'b1;
            next_ans.wr_lo = 1'b1;
            case (req.op)
                alu_pkg::move_sized:
                    next_ans.result = (opnd_a & ~mask) | bm;
                alu_pkg::move_byte_sign_ext:
                    next_ans.result = {opnd_a[31:16], {8{opnd_b[7]}}, opnd_b[7:0]};       // RL3
                alu_pkg::move_byte_zero_ext:
                    next_ans.result = {opnd_a[31:16], 8'h00, opnd_b[7:0]};                // RL4
                alu_pkg::move_word_sign_ext: begin
                    next_ans.result = {{16{opnd_b[15]}}, opnd_b[15:0]};                   // RL3
                    next_ans.wr_hi  = 1'b1;
                end
                alu_pkg::move_word_zero_ext: begin
                    next_ans.result = {16'h0000, opnd_b[15:0]};                           // RL4
                    next_ans.wr_hi  = 1'b1;
                end
                alu_pkg::move_double: begin
                    next_ans.result = opnd_b;                                             // RL5
                    next_ans.wr_hi  = 1'b1;
                end
                alu_pkg::add_sized, alu_pkg::add_carry_sized, alu_pkg::add_double: begin
                    next_ans.result   = (opnd_a & ~mask) | (sum[31:0] & mask);            // RL6 RL13
                    next_ans.wr_hi    = (req.op == alu_pkg::add_double);                  // RL6
                    next_flags.carry  = sum[msb+1];                                       // RL23
                    next_flags.zero   = ((sum[31:0] & mask) == alu_pkg::bool_false);      // RL23
                    next_flags.ovf    = (am[msb] == bm[msb]) && (sum[msb] != am[msb]);    // RL23
                end
                alu_pkg::sub_sized, alu_pkg::sub_borrow_sized, alu_pkg::sub_double: begin
                    next_ans.result   = (opnd_a & ~mask) | (diff[31:0] & mask);           // RL12 RL14
                    next_ans.wr_hi    = (req.op == alu_pkg::sub_double);                  // RL14
                    next_flags.carry  = diff[msb+1];                                      // RL23
                    next_flags.zero   = ((diff[31:0] & mask) == alu_pkg::bool_false);     // RL23
                    next_flags.ovf    = (am[msb] != bm[msb]) && (diff[msb] != am[msb]);   // RL23
                end
                alu_pkg::compare_sized, alu_pkg::compare_double: begin
                    next_ans.wr_lo   = 1'b0;                                              // RL15
                    next_flags.zero  = (am == bm);                                        // RL15 RL23
                    next_flags.low   = (am < bm);                                         // RL15 RL23
                    next_flags.neg   = (diff[msb] != ((am[msb] != bm[msb]) && (diff[msb] != am[msb])));
                end
                alu_pkg::mac_fractional: begin
                    next_ans.result = opnd_a + {prod_s[30:0], 1'b0};                      // RL7
                    next_ans.wr_hi  = 1'b1;
                end
                alu_pkg::mac_signed: begin
                    next_ans.result = opnd_a + prod_s;                                    // RL7
                    next_ans.wr_hi  = 1'b1;
                end
                alu_pkg::mac_unsigned: begin
                    next_ans.result = opnd_a + prod_u;                                    // RL8
                    next_ans.wr_hi  = 1'b1;
                end
                alu_pkg::mult_sized:
                    next_ans.result = (opnd_a & ~mask) | (prod_u & mask);                 // RL9
                alu_pkg::mult_signed_byte:
                    next_ans.result = {opnd_a[31:16], prod_sb};                           // RL10
                alu_pkg::mult_signed_word: begin
                    next_ans.result = prod_s;                                             // RL11
                    next_ans.wr_hi  = 1'b1;
                end
                alu_pkg::mult_unsigned_word: begin
                    next_ans.result = prod_u;                                             // RL11
                    next_ans.wr_hi  = 1'b1;
                end
                alu_pkg::branch_if_zero: begin
                    next_ans.wr_lo        = 1'b0;
                    next_ans.branch_taken = src_is_zero;                                  // RL16
                end
                alu_pkg::branch_if_nonzero: begin
                    next_ans.wr_lo        = 1'b0;
                    next_ans.branch_taken = !src_is_zero;                                 // RL16
                end
                alu_pkg::and_sized, alu_pkg::and_double: begin
                    next_ans.result = (opnd_a & ~mask) | (am & bm);                       // RL17 RL20
                    next_ans.wr_hi  = (req.op == alu_pkg::and_double);                    // RL20
                end
                alu_pkg::or_sized, alu_pkg::or_double: begin
                    next_ans.result = (opnd_a & ~mask) | (am | bm);                       // RL18 RL20
                    next_ans.wr_hi  = (req.op == alu_pkg::or_double);                     // RL20
                end
                alu_pkg::xor_sized, alu_pkg::xor_double: begin
                    next_ans.result = (opnd_a & ~mask) | (am ^ bm);                       // RL19 RL20
                    next_ans.wr_hi  = (req.op == alu_pkg::xor_double);                    // RL20
                end
                alu_pkg::save_condition:
                    next_ans.result = cond_true ? alu_pkg::bool_true : alu_pkg::bool_false; // RL21
                default: begin
                    // unknown codes answer without any write
                    next_ans.wr_lo = 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // answer and flag registers
    // ------------------------------------------------------------
    // a flag update by an issued operation wins over a core load
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ans   <= alu_pkg::answer_reset;
            flags <= alu_pkg::flags_reset;
        end else begin
            ans   <= next_ans;
            flags <= next_flags;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_issue(alu_pkg::alu_op_t o);
        req_valid && (req.op == o);
    endsequence

    property p_answer_follows;
        @(posedge sys_clk) disable iff (reset) req_valid |=> ans.valid ##1 (ans.valid == $past(req_valid));
    endproperty
    a_answer_follows: assert property (p_answer_follows) else $error("answer missing after issue"); // RL1

    property p_compare_no_write;
        @(posedge sys_clk) disable iff (reset)
            (s_issue(alu_pkg::compare_sized) or s_issue(alu_pkg::compare_double)) |=> (!ans.wr_lo && !ans.wr_hi);
    endproperty
    a_compare_no_write: assert property (p_compare_no_write) else $error("compare wrote a register"); // RL15

    property p_sign_ext_byte;
        @(posedge sys_clk) disable iff (reset)
            s_issue(alu_pkg::move_byte_sign_ext) ##0 !req.use_imm |=>
                ans.result[15:0] == {{8{$past(req.src[7])}}, $past(req.src[7:0])};
    endproperty
    a_sign_ext_byte: assert property (p_sign_ext_byte) else $error("byte sign extension wrong"); // RL3

    property p_zero_ext_word;
        @(posedge sys_clk) disable iff (reset)
            s_issue(alu_pkg::move_word_zero_ext) |=> (ans.result[31:16] == 16'h0000) && ans.wr_hi;
    endproperty
    a_zero_ext_word: assert property (p_zero_ext_word) else $error("word zero extension wrong"); // RL4

    property p_save_bool;
        @(posedge sys_clk) disable iff (reset)
            s_issue(alu_pkg::save_condition) |=> (ans.result[31:1] == 31'h00000000);
    endproperty
    a_save_bool: assert property (p_save_bool) else $error("saved condition is not boolean"); // RL21

    property p_branch_zero;
        @(posedge sys_clk) disable iff (reset)
            s_issue(alu_pkg::branch_if_zero) ##0 (req.size == alu_pkg::size_word) |=>
                ans.branch_taken == ($past(req.src[15:0]) == 16'h0000);
    endproperty
    a_branch_zero: assert property (p_branch_zero) else $error("zero branch decision wrong"); // RL16

    property p_add_double;
        @(posedge sys_clk) disable iff (reset)
            s_issue(alu_pkg::add_double) ##0 !req.use_imm |=>
                ans.result == 32'($past(req.dest) + $past(req.src)) && ans.wr_hi;
    endproperty
    a_add_double: assert property (p_add_double) else $error("pair add result wrong"); // RL6

    property p_sub_flags;
        @(posedge sys_clk) disable iff (reset)
            s_issue(alu_pkg::sub_double) ##0 (!req.use_imm && !flags_load) |=>
                flags.carry == ($past(req.dest) < $past(req.src)) &&
                flags.zero == ($past(req.dest) == $past(req.src));
    endproperty
    a_sub_flags: assert property (p_sub_flags) else $error("subtract flags wrong"); // RL23

    property p_mult_byte;
        @(posedge sys_clk) disable iff (reset)
            s_issue(alu_pkg::mult_signed_byte) ##0 !req.use_imm |=>
                ans.result[15:0] == 16'($signed($past(req.dest[7:0])) * $signed($past(req.src[7:0])));
    endproperty
    a_mult_byte: assert property (p_mult_byte) else $error("signed byte product wrong"); // RL10

endmodule // risc_integer_alu_datapath

// file: testbench/pair_store.sv
// register-file stand-in that takes the datapath's write-backs
`timescale 1ns/1ns
module pair_store (
    input  wire logic             sys_clk,  // core clock
    input  wire alu_pkg::answer_t ans,      // write-back from the datapath
    output logic [31:0]           pair      // {higher reg, lower reg}
);
    // ----------------------------------------
    // write-back, each half to its own register
    // ----------------------------------------
    always @(posedge sys_clk) begin
        if (ans.valid && ans.wr_lo) pair[15:0] <= ans.result[15:0];
        if (ans.valid && ans.wr_hi) pair[31:16] <= ans.result[31:16];
    end
endmodule // pair_store

// file: testbench/tb_top.sv
// self-checking bench of the integer execution datapath
`timescale 1ns/1ns
module tb_top;
    logic              sys_clk = 0, reset = 1, req_valid = 0, flags_load = 0;  // driven inputs
    alu_pkg::request_t req = '0, r;                       // request on the port, scratch
    alu_pkg::flags_t   flags_in = '0, fz = '0, flags;     // status in, clear, out
    alu_pkg::answer_t  ans, q[$];                         // answer and expected notes
    logic [31:0]       pair;                              // pair held by the register stand-in
    int                n_errors = 0, compares = 0;        // tallies

    always #2 sys_clk = ~sys_clk;
    risc_integer_alu_datapath i_risc_integer_alu_datapath (.sys_clk(sys_clk), .reset(reset),
        .req_valid(req_valid), .req(req), .flags_load(flags_load), .flags_in(flags_in), .ans(ans), .flags(flags));
    pair_store i_pair_store (.sys_clk(sys_clk), .ans(ans), .pair(pair));

    // ----------------------------------------
    // reference: condition table and datapath
    // ----------------------------------------
    function automatic logic cv(logic [3:0] c, alu_pkg::flags_t f);
        logic [15:0] t;
        t = {2'b00, !f.neg, f.neg, !f.low, f.low, !f.ovf, f.ovf, f.neg | f.zero, !f.neg & !f.zero,
             f.low | f.zero, !f.low & !f.zero, !f.carry, f.carry, !f.zero, f.zero};
        return t[c];
    endfunction

    function automatic alu_pkg::answer_t model(alu_pkg::request_t r, alu_pkg::flags_t f);
        logic [31:0]        d, s, x;
        logic signed [31:0] ms, mw;
        logic signed [15:0] mb;
        logic [1:0]         k;   // 0 sized, 1 pair, 2 no write, 3 lower only
        alu_pkg::answer_t   a;
        d = r.dest;
        s = r.use_imm ? r.imm : r.src;
        ms = $signed(r.src[15:0]) * $signed(r.src2);
        mw = $signed(d[15:0]) * $signed(s[15:0]);
        mb = $signed(d[7:0]) * $signed(s[7:0]);
        k = r.op inside {5'h00, 5'h06, 5'h07, 5'h0c, 5'h10, 5'h12, 5'h17, 5'h19, 5'h1b} ? 2'h0 :
            r.op inside {5'h01, 5'h02, 5'h0d, 5'h1d} ? 2'h3 : r.op inside {[5'h13:5'h16], 5'h1e, 5'h1f} ? 2'h2 : 2'h1;
        case (r.op)
            5'h00, 5'h05: x = s;
            5'h01: x = {{24{s[7]}}, s[7:0]};
            5'h02: x = {24'h0, s[7:0]};
            5'h03: x = {{16{s[15]}}, s[15:0]};
            5'h04: x = {16'h0, s[15:0]};
            5'h06, 5'h08: x = d + s;
            5'h07: x = d + s + f.carry;
            5'h09: x = d + (ms << 1);
            5'h0a: x = d + ms;
            5'h0b: x = d + r.src[15:0] * r.src2;
            5'h0c: x = d * s;
            5'h0d: x = {16'h0, mb};
            5'h0e: x = mw;
            5'h0f: x = d[15:0] * s[15:0];
            5'h10, 5'h11: x = d - s;
            5'h12: x = d - s - f.carry;
            5'h17, 5'h18: x = d & s;
            5'h19, 5'h1a: x = d | s;
            5'h1b, 5'h1c: x = d ^ s;
            5'h1d: x = {31'h0, cv(r.cond, f)};
            default: x = 32'h0;
        endcase
        if (r.size == alu_pkg::size_byte && k == 2'h0) x[15:8] = d[15:8];
        a = alu_pkg::answer_reset;
        a.valid = 1'b1;
        a.result = k == 2'h1 ? x : k == 2'h2 ? 32'h0 : {d[31:16], x[15:0]};
        a.wr_lo = k != 2'h2;
        a.wr_hi = k == 2'h1;
        a.branch_taken = r.op inside {5'h15, 5'h16} && ((r.size == alu_pkg::size_byte ? r.src[7:0] == 8'h0 :
                         r.src[15:0] == 16'h0) ^ (r.op == 5'h16));
        return a;
    endfunction

    // ----------------------------------------
    // compare, drive, watch, finish
    // ----------------------------------------
    task automatic check(logic [63:0] e, logic [63:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    // optional status load cycle, then a one-cycle issue
    task automatic issue(alu_pkg::request_t rq, alu_pkg::flags_t f, bit ld);
        if (ld) begin
            @(posedge sys_clk);
            req_valid <= 1'b0;
            flags_load <= 1'b1;
            flags_in <= f;
        end
        @(posedge sys_clk);
        flags_load <= 1'b0;
        req_valid <= 1'b1;
        req <= rq;
        q.push_back(model(rq, f));
    endtask

    // answers are settled by the falling edge
    always @(negedge sys_clk) if (ans.valid === 1'b1) check(q.size() ? q.pop_front() : '1, ans);

    task automatic conclude();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #80000;
        n_errors++;
        conclude();
    end

    initial begin
        void'($urandom(9248));
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        @(negedge sys_clk);
        check(64'h0, {ans, flags});
        $display("test reset done");
        // every opcode against both sizes and all sixteen condition codes
        for (int i = 0; i < 512; i++) begin
            r.op = alu_pkg::alu_op_t'(5'(i));
            r.size = alu_pkg::op_size_t'(2'(i / 32 % 2));
            r.cond = alu_pkg::cond_t'(4'(i / 32));
            r.dest = $urandom;
            r.src = $urandom;
            r.src2 = 16'($urandom);
            r.imm = $urandom;
            r.src[15:0] &= (i / 64 % 4 == 0) ? 16'h0 : (i / 64 % 4 == 1) ? 16'hff00 : 16'hffff;
            r.use_imm = !(r.op inside {[5'h01:5'h04], [5'h09:5'h0b], 5'h0d, 5'h15, 5'h16, 5'h1d}) && 1'($urandom);
            if (r.op inside {5'h01, 5'h02, 5'h0d, 5'h1d}) r.dest[31:16] = 16'h0;
            issue(r, alu_pkg::flags_t'(5'($urandom)), 1'b1);
        end
        $display("test opcode sweep done");
        // back-to-back: status of one operation feeds the next
        r = '0;
        r.op = alu_pkg::add_double;
        r.dest = 32'hfffeffff;
        r.src = 32'h00040002;
        issue(r, fz, 1'b1);
        r = '0;
        r.op = alu_pkg::save_condition;
        r.cond = alu_pkg::cond_cs;
        issue(r, alu_pkg::flags_t'(5'b10000), 1'b0);
        r.op = alu_pkg::compare_sized;
        r.size = alu_pkg::size_word;
        r.dest = 32'h5;
        r.src = 32'h9;
        issue(r, fz, 1'b0);
        r = '0;
        r.op = alu_pkg::save_condition;
        r.cond = alu_pkg::cond_lt;
        issue(r, alu_pkg::flags_t'(5'b10110), 1'b0);
        r.op = alu_pkg::sub_borrow_sized;
        r.dest = 32'ha;
        r.src = 32'h3;
        issue(r, alu_pkg::flags_t'(5'b10110), 1'b0);
        @(posedge sys_clk);
        req_valid <= 1'b0;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        check(32'h00030006, pair);
        check(5'b00110, flags);
        check(0, q.size());
        $display("test back-to-back done");
        conclude();
    end
endmodule // tb_top
